/* hdl/ats_seq.sv */
module ats_seq
  import ats_pkg::*;
(
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // converter results, same clock
  input  wire ats_pkg::ats_conv_t conv,
  // sample clock and hardware triggers from pins
  input  wire logic              sclk_pin,
  input  wire logic              hw_start_pin,
  input  wire logic              hw_stop_pin,
  // front-end controls
  output logic [ats_pkg::NCH-1:0] ac_couple,
  output logic                   acq_active
);
  import ats_pkg::*;

  // pin synchronisers: stage 1 read only by stage 2
  logic [2:0] s1_q, s2_q, s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {hw_stop_pin, hw_start_pin, sclk_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic tick, hw_start_ev, hw_stop_ev;
  assign tick        = s2_q[0] & ~s3_q[0];
  assign hw_start_ev = s2_q[1] & ~s3_q[1];
  assign hw_stop_ev  = s2_q[2] & ~s3_q[2];

  // registers
  logic [31:0]   ctrl_q;
  logic [AW:0]   count_q;
  logic [15:0]   sdly_q, pdly_q;
  logic [1:0]    trig_q;
  logic [DW-1:0] level_q, hyst_q;
  logic [NCH-1:0] couple_q;
  ats_mode_t     mode;
  logic [1:0]    achan;
  assign mode  = ats_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);
  assign achan = ctrl_q[CTRL_ACHAN +: 2];

  logic wr, rd;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;

  function automatic logic known(input logic [7:0] a);
    known = (a == OFF_CTRL) || (a == OFF_COUNT) || (a == OFF_DELAY) || (a == OFF_TRIG)
         || (a == OFF_LEVEL) || (a == OFF_HYST) || (a == OFF_CMD) || (a == OFF_STATUS)
         || (a == OFF_INST) || (a == OFF_FIFO) || (a == OFF_COUPLE);
  endfunction : known
  assign pslverr = psel & penable & ~known(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= CTRL_RST;
      count_q  <= COUNT_RST;
      sdly_q   <= 16'h0000;
      pdly_q   <= 16'h0000;
      trig_q   <= 2'h0;
      level_q  <= '0;
      hyst_q   <= '0;
      couple_q <= '0;
    end else if (wr) begin
      case (paddr)
        OFF_CTRL:   ctrl_q <= pwdata;
        OFF_COUNT:  count_q <= (pwdata[AW:0] == 5'h00 || pwdata[AW:0] > COUNT_RST) ? COUNT_RST : pwdata[AW:0];
        OFF_DELAY: begin
          sdly_q <= pwdata[15:0];
          pdly_q <= pwdata[31:16];
        end
        OFF_TRIG:   trig_q <= pwdata[1:0];
        OFF_LEVEL:  level_q <= pwdata[DW-1:0];
        OFF_HYST:   hyst_q <= pwdata[DW-1:0];
        OFF_COUPLE: couple_q <= pwdata[NCH-1:0];
        default: ;
      endcase
    end
  end
  assign ac_couple = couple_q;

  logic sw_start, sw_stop;
  assign sw_start = wr && paddr == OFF_CMD && pwdata[CMD_START];
  assign sw_stop  = wr && paddr == OFF_CMD && pwdata[CMD_STOP];

  // latest conversion per channel
  logic [DW-1:0] latest_q [NCH];
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_lat
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) latest_q[g] <= '0;
        else if (conv.valid && conv.chan == 2'(g)) latest_q[g] <= conv.data;
      end
    end
  endgenerate

  logic [1:0] inst_ch_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) inst_ch_q <= 2'h0;
    else if (wr && paddr == OFF_CMD) inst_ch_q <= pwdata[CMD_INSTCH +: 2];
  end

  // analog trigger, signed compare
  logic signed [DW-1:0] av, lv, hv;
  logic                 armed_q, above_q, a_trig;
  assign av = signed'(latest_q[achan]);
  assign lv = signed'(level_q);
  assign hv = signed'(hyst_q);
  logic signed [DW:0] lo_th, hi_th;
  assign lo_th = {lv[DW-1], lv} - {hv[DW-1], hv};
  assign hi_th = {lv[DW-1], lv} + {hv[DW-1], hv};
  logic new_s;
  assign new_s = conv.valid && conv.chan == achan;
  logic signed [DW-1:0] nv;
  assign nv = signed'(conv.data);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b1;
      above_q <= 1'b0;
    end else if (new_s) begin
      above_q <= nv >= lv;
      if (a_trig) armed_q <= 1'b0;
      else if (!trig_q[TRIG_FALL] && {nv[DW-1], nv} < lo_th) armed_q <= 1'b1;
      else if (trig_q[TRIG_FALL] && {nv[DW-1], nv} > hi_th) armed_q <= 1'b1;
    end
  end
  assign a_trig = new_s && armed_q && trig_q[TRIG_ANALOG] &&
                  (trig_q[TRIG_FALL] ? (above_q && nv < lv) : (!above_q && nv >= lv));

  logic hw_start, hw_stop;
  assign hw_start = trig_q[TRIG_ANALOG] ? a_trig : hw_start_ev;
  assign hw_stop  = hw_stop_ev;

  // sequencer
  ats_state_t st_q;
  logic [15:0] dcnt_q;
  logic [AW:0] ncap_q;
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] fill_q;
  logic start_ok, stop_ok;
  logic pre_like;
  assign pre_like = (mode == ATS_PRE) || (mode == ATS_ABOUT);
  assign start_ok = pre_like ? sw_start
                  : (ctrl_q[CTRL_HWSTART] ? hw_start : sw_start);
  assign stop_ok  = pre_like ? hw_stop
                  : (ctrl_q[CTRL_HWSTOP] ? hw_stop : sw_stop);
  logic cap;
  assign cap = (st_q == ST_RUN || st_q == ST_PDLY) && tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_IDLE;
      dcnt_q <= 16'h0000;
      ncap_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: if (start_ok) begin
          ncap_q <= '0;
          if (!pre_like && ctrl_q[CTRL_HWSTART] && sdly_q != 16'h0000) begin
            st_q   <= ST_SDLY;
            dcnt_q <= sdly_q;
          end else st_q <= ST_RUN;
        end
        ST_SDLY: if (tick) begin
          if (dcnt_q == 16'h0001) st_q <= ST_RUN;
          dcnt_q <= dcnt_q - 16'h0001;
        end
        ST_RUN: begin
          if (cap) ncap_q <= ncap_q + 5'h01;
          if (mode == ATS_POST && cap && ncap_q + 5'h01 == count_q) st_q <= ST_DONE;
          else if (stop_ok) begin
            if ((mode == ATS_ABOUT || (mode == ATS_STREAM && ctrl_q[CTRL_HWSTOP])) &&
                pdly_q != 16'h0000) begin
              st_q   <= ST_PDLY;
              dcnt_q <= pdly_q;
            end else st_q <= ST_DONE;
          end
        end
        ST_PDLY: if (tick) begin
          if (dcnt_q == 16'h0001) st_q <= ST_DONE;
          dcnt_q <= dcnt_q - 16'h0001;
        end
        ST_DONE: if (ctrl_q[CTRL_RETRIG] && fill_q == '0 || ctrl_q[CTRL_RETRIG] && pre_like) begin
          st_q <= ST_IDLE;
        end else if (sw_start) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign acq_active = (st_q == ST_RUN) || (st_q == ST_PDLY);

  // buffer memory: circular for pre/about, queue otherwise
  logic [DW+1:0] mem_q [DEPTH];
  logic pop;
  assign pop = rd && paddr == OFF_FIFO && fill_q != '0;
  always_ff @(posedge pclk) begin
    if (cap) mem_q[wp_q] <= {conv.chan, latest_q[0]};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end else begin
      if (st_q == ST_IDLE && start_ok && pre_like) begin
        wp_q <= '0;
        rp_q <= '0;
        fill_q <= '0;
      end else begin
        if (cap) wp_q <= (wp_q + 4'h1 == count_q[AW-1:0] && pre_like) ? '0 : wp_q + 4'h1;
        if (pop) rp_q <= (rp_q + 4'h1 == count_q[AW-1:0] && pre_like) ? '0 : rp_q + 4'h1;
        if (cap && pre_like && fill_q == count_q) rp_q <= (rp_q + 4'h1 == count_q[AW-1:0]) ? '0 : rp_q + 4'h1;
        if (cap && !pop && !(pre_like && fill_q == count_q) && fill_q != COUNT_RST) fill_q <= fill_q + 5'h01;
        else if (pop && !cap) fill_q <= fill_q - 5'h01;
      end
    end
  end

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_CTRL:   prdata <= ctrl_q;
        OFF_COUNT:  prdata <= {27'h0, count_q};
        OFF_DELAY:  prdata <= {pdly_q, sdly_q};
        OFF_TRIG:   prdata <= {30'h0, trig_q};
        OFF_LEVEL:  prdata <= {8'h00, level_q};
        OFF_HYST:   prdata <= {8'h00, hyst_q};
        OFF_STATUS: prdata <= {22'h0, fill_q, st_q};
        OFF_INST:   prdata <= {8'h00, latest_q[inst_ch_q]};
        OFF_FIFO:   prdata <= {6'h00, mem_q[rp_q]};
        OFF_COUPLE: prdata <= {28'h0, couple_q};
        default:    prdata <= 32'h0;
      endcase
    end
  end

  // checks
  post_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN && mode == ATS_POST && cap && ncap_q + 5'h01 == count_q |=> st_q == ST_DONE)
    else $error("post-trigger did not stop at count");
  idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_IDLE && !start_ok |=> st_q == ST_IDLE)
    else $error("left standby without start");
  no_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    !acq_active |-> !cap)
    else $error("capture outside active");
  pdly_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_PDLY && !tick |=> st_q == ST_PDLY)
    else $error("stop delay broken by event");
  sdly_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_SDLY && dcnt_q > 16'h0001 |=> st_q == ST_SDLY)
    else $error("start delay ended early");
  pre_sw_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN && pre_like && !hw_stop |=> st_q == ST_RUN)
    else $error("pre-trigger stopped without hw stop");
  fill_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    fill_q <= COUNT_RST)
    else $error("buffer fill overflow");
  couple_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFF_COUPLE |=> ac_couple == $past(pwdata[NCH-1:0]))
    else $error("coupling not stored");
  run_cov: cover property (@(posedge pclk) disable iff (!presetn) st_q == ST_RUN ##1 st_q == ST_DONE);
  pdly_cov: cover property (@(posedge pclk) disable iff (!presetn) st_q == ST_PDLY ##1 st_q == ST_DONE);
  trig_cov: cover property (@(posedge pclk) disable iff (!presetn) a_trig);
endmodule : ats_seq

/* shared/ats_pkg.sv */
// Behaviour
// - instant read returns latest conversion result
// - buffered results written to buffer memory
// - standby until start trigger arrives
// - one sample per sample-clock rising edge
// - active until stop trigger ends acquisition
// - start and stop delays counted in samples
// - one-buffer captures programmed sample count
// - post-trigger stops itself after count
// - post-trigger start delay only for hardware
// - pre-trigger keeps count samples before stop
// - about-trigger stops delay samples after trigger
// - streaming runs unbounded until stop
// - streaming hardware triggers allow delays
// - re-trigger rearms without reconfiguration
// - re-triggered post ignores start while running
// - re-triggered about ignores stop during delay
// - analog trigger channel, polarity, level, hysteresis
// - rising fires upward, rearms below level-hyst
// - falling fires downward, rearms above level+hyst
// - per-channel AC/DC coupling setting
package ats_pkg;
  localparam int NCH   = 4;
  localparam int DW    = 24;
  localparam int DEPTH = 16;
  localparam int AW    = 4;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_DELAY  = 8'h08;
  localparam logic [7:0] OFF_TRIG   = 8'h0c;
  localparam logic [7:0] OFF_LEVEL  = 8'h10;
  localparam logic [7:0] OFF_HYST   = 8'h14;
  localparam logic [7:0] OFF_CMD    = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_INST   = 8'h20;
  localparam logic [7:0] OFF_FIFO   = 8'h24;
  localparam logic [7:0] OFF_COUPLE = 8'h28;

  // ctrl fields
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_RETRIG  = 2;
  localparam int CTRL_HWSTART = 3;
  localparam int CTRL_HWSTOP  = 4;
  localparam int CTRL_ACHAN   = 8;
  // trig fields
  localparam int TRIG_ANALOG  = 0;
  localparam int TRIG_FALL    = 1;
  // cmd bits
  localparam int CMD_START    = 0;
  localparam int CMD_STOP     = 1;
  localparam int CMD_INSTCH   = 4;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [AW:0] COUNT_RST = 5'h10;

  typedef enum logic [1:0] {
    ATS_POST   = 2'h0,
    ATS_PRE    = 2'h1,
    ATS_ABOUT  = 2'h2,
    ATS_STREAM = 2'h3
  } ats_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SDLY   = 5'h02,
    ST_RUN    = 5'h04,
    ST_PDLY   = 5'h08,
    ST_DONE   = 5'h10
  } ats_state_t;

  typedef struct packed {
    logic          valid;
    logic [1:0]    chan;
    logic [DW-1:0] data;
  } ats_conv_t;
endpackage : ats_pkg

/* test/ats_conv_model.sv */
module ats_conv_model
  import ats_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // converter stream and sample clock
  output ats_pkg::ats_conv_t conv,
  output logic               sclk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]    div_q;
  logic [DW-1:0] ramp_q;
  // converters never wait on the host; a rising ramp feeds the analog trigger
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q    <= '0;
      ramp_q   <= '0;
      conv     <= '0;
      sclk_pin <= 1'b0;
    end else begin
      div_q <= div_q + 5'h01;
      if (div_q[1:0] == 2'h3) begin
        sclk_pin <= ~sclk_pin;
      end
      conv.valid <= (div_q[2:0] == 3'h0);
      if (div_q[2:0] == 3'h0) begin
        conv.chan <= conv.chan + 2'h1;
        conv.data <= ramp_q;
        ramp_q    <= ramp_q + 24'h000111;
      end else begin
        // stale data is scrambled so nobody samples it by luck
        conv.data <= ~conv.data;
      end
    end
  end
endmodule : ats_conv_model

/* test/tb_top.sv */
module tb_top
  import ats_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic hw_start_pin = 0, hw_stop_pin = 0, pready, pslverr, acq_active, sclk_pin, err;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata, rd, v;
  logic [NCH-1:0] ac_couple;
  ats_conv_t      conv;
  logic [DW-1:0]  last [NCH];
  logic [DW-1:0]  ch0 [$];
  int n_errors = 0, compares = 0, scnt = 0, s0, s1, n, c;
  int hit [$];

  always #5 pclk = ~pclk;
  ats_conv_model PM (.pclk, .presetn, .conv, .sclk_pin);
  ats_seq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .conv, .sclk_pin, .hw_start_pin, .hw_stop_pin, .ac_couple, .acq_active);

  // reference: latest result per channel, and every channel 0 result
  always @(posedge pclk) begin
    if (conv.valid === 1'b1) begin
      last[conv.chan] = conv.data;
      if (conv.chan == 2'h0) ch0.push_back(conv.data);
    end
  end
  always @(posedge sclk_pin) scnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle so psel is never driven twice in one step
    @(posedge pclk);
  endtask : apb

  task automatic st(input logic [4:0] s);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[4:0]), 32'(s), "state");
  endtask : st

  // pin pulse away from sample edges, held 3 cycles
  task automatic hw(input bit stop);
    @(negedge sclk_pin);
    if (stop) hw_stop_pin <= 1'b1;
    else hw_start_pin <= 1'b1;
    s0 = scnt;
    repeat (3) @(posedge pclk);
    hw_stop_pin  <= 1'b0;
    hw_start_pin <= 1'b0;
  endtask : hw

  task automatic wact(input logic lv);
    for (int i = 0; i < 600 && acq_active !== lv; i++) @(posedge pclk);
  endtask : wact

  task automatic drain;
    int k;
    apb(1'b0, OFF_STATUS, 32'h0);
    k = int'(rd[9:5]);
    repeat (k) apb(1'b0, OFF_FIFO, 32'h0);
  endtask : drain

  task automatic cfg(input int cnt, input logic [31:0] dly, input logic [31:0] ctl);
    apb(1'b1, OFF_COUNT, 32'(cnt));
    apb(1'b1, OFF_DELAY, dly);
    apb(1'b1, OFF_CTRL, ctl);
    // a finished run without re-trigger waits in done for one start
    apb(1'b0, OFF_STATUS, 32'h0);
    if (rd[4:0] == ST_DONE) apb(1'b1, OFF_CMD, 32'h1);
  endtask : cfg

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    #1000000;
    n_errors++;
    test_done;
  end

  initial begin
    void'($urandom(32'hcf620dc4));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    st(ST_IDLE);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RST, "ctrl reset");
    apb(1'b1, 8'h40, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1, "unmapped");
    v = $urandom;
    apb(1'b1, OFF_COUPLE, v);
    chk(32'(ac_couple), 32'(v[NCH-1:0]), "coupling");
    $display("done: reset and coupling");
    for (c = 0; c < NCH; c++) begin
      apb(1'b1, OFF_CMD, 32'(c) << CMD_INSTCH);
      do @(posedge pclk); while (!(conv.valid === 1'b1 && conv.chan == 2'(c)));
      apb(1'b0, OFF_INST, 32'h0);
      chk(32'(rd[DW-1:0]), 32'(last[c]), "instant");
    end
    $display("done: instant");
    // at least two samples, so the run outlasts the status read
    n = $urandom_range(16, 2);
    cfg(n, 32'h0, 32'(ATS_POST));
    apb(1'b1, OFF_CMD, 32'h1);
    wact(1'b1);
    st(ST_RUN);
    wact(1'b0);
    st(ST_DONE);
    chk(32'(rd[9:5]), 32'(n), "post fill");
    repeat (n) begin
      apb(1'b0, OFF_FIFO, 32'h0);
      hit = ch0.find_index(x) with (x == rd[DW-1:0]);
      chk(32'(hit.size() > 0), 32'h1, "pop");
    end
    $display("done: post software start");
    n = $urandom_range(5, 1);
    cfg(1, 32'(n), 32'(ATS_POST) | 32'h8);
    hw(1'b0);
    st(ST_SDLY);
    wact(1'b1);
    chk(32'(scnt - s0), 32'(n), "start delay");
    wact(1'b0);
    drain;
    $display("done: post hardware start");
    cfg(5, 32'h0, 32'(ATS_PRE) | 32'h10);
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (12) @(negedge sclk_pin);
    hw(1'b1);
    wact(1'b0);
    st(ST_DONE);
    chk(32'(rd[9:5]), 32'h5, "pre fill");
    drain;
    $display("done: pre");
    cfg(3, 32'h0003_0000, 32'(ATS_ABOUT) | 32'h14);
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (6) @(negedge sclk_pin);
    hw(1'b1);
    s1 = s0;
    hw(1'b1);
    wact(1'b0);
    chk(32'(scnt - s1), 32'h3, "stop delay");
    drain;
    apb(1'b1, OFF_CMD, 32'h1);
    wact(1'b1);
    chk(32'(acq_active), 32'h1, "rearm about");
    hw(1'b1);
    wact(1'b0);
    drain;
    $display("done: about");
    cfg(4, 32'h0, 32'(ATS_POST) | 32'h4);
    apb(1'b1, OFF_CMD, 32'h1);
    wact(1'b1);
    apb(1'b1, OFF_CMD, 32'h1);
    wact(1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[9:5]), 32'h4, "retrig fill");
    drain;
    st(ST_IDLE);
    $display("done: post retrigger");
    cfg(4, 32'h0, 32'(ATS_STREAM));
    apb(1'b1, OFF_CMD, 32'h1);
    wact(1'b1);
    repeat (8) @(negedge sclk_pin);
    chk(32'(acq_active), 32'h1, "stream runs");
    apb(1'b1, OFF_CMD, 32'h2);
    wact(1'b0);
    chk(32'(acq_active), 32'h0, "stream stop");
    drain;
    $display("done: stream");
    apb(1'b1, OFF_LEVEL, 32'(last[0] + 24'h002000));
    apb(1'b1, OFF_HYST, 32'h0);
    apb(1'b1, OFF_TRIG, 32'h1);
    cfg(4, 32'h0, 32'(ATS_STREAM) | 32'h8);
    chk(32'(acq_active), 32'h0, "below level");
    wact(1'b1);
    chk(32'(acq_active), 32'h1, "analog fire");
    apb(1'b1, OFF_CMD, 32'h2);
    wact(1'b0);
    chk(32'(acq_active), 32'h0, "analog stop");
    $display("done: analog trigger");
    test_done;
  end
endmodule : tb_top
